// >>> mie_defs.vh
/*
 * Constants of the instruction execution block: register offsets, field
 * positions, reset values, opcodes and timing counts.
 * Assumes inclusion by every design file that needs them.
 */
`ifndef MIE_DEFS_VH
`define MIE_DEFS_VH

// Register byte offsets
`define MIE_OFF_CTRL   8'h00
`define MIE_OFF_STAT   8'h04
`define MIE_OFF_PC     8'h08
`define MIE_OFF_ACC    8'h0c
`define MIE_OFF_TABLE_HIGH_BYTE   8'h10
`define MIE_OFF_WDT    8'h14
`define MIE_OFF_MADDR  8'h18
`define MIE_OFF_MDATA  8'h1c
`define MIE_OFF_LAST   8'h20

// Control fields
`define MIE_CTRL_RUN   0
`define MIE_CTRL_GIE   1
`define MIE_CTRL_WAKE  2

// Status fields
`define MIE_ST_C       0
`define MIE_ST_AC      1
`define MIE_ST_Z       2
`define MIE_ST_OV      3
`define MIE_ST_PDF     4
`define MIE_ST_TO      5
`define MIE_ST_HALT    6
`define MIE_ST_BUSY    7

// Reset values
`define MIE_RST_PC     11'h000
`define MIE_RST_ACC    8'h00
`define MIE_RST_SP     3'h0

// Special data addresses and pages
`define MIE_PCL_ADDR   8'h02
`define MIE_LAST_PAGE  3'h7

// System clocks per instruction cycle
`define MIE_SYS_PER_ICYC 4'd4

// Opcodes, instruction bits 15:11
`define MIE_OP_NOP     5'h00
`define MIE_OP_JMP     5'h01
`define MIE_OP_CALL    5'h02
`define MIE_OP_RET     5'h03
`define MIE_OP_RETA    5'h04
`define MIE_OP_INTERRUPT_RETURN    5'h05
`define MIE_OP_SKZ     5'h06
`define MIE_OP_SKZA    5'h07
`define MIE_OP_SKBC    5'h08
`define MIE_OP_SKBS    5'h09
`define MIE_OP_INCSK   5'h0a
`define MIE_OP_DECSK   5'h0b
`define MIE_OP_INCSKA  5'h0c
`define MIE_OP_DECSKA  5'h0d
`define MIE_OP_TRDC    5'h0e
`define MIE_OP_TRDL    5'h0f
`define MIE_OP_CLRM    5'h10
`define MIE_OP_SETM    5'h11
`define MIE_OP_CLRB    5'h12
`define MIE_OP_WDC     5'h13
`define MIE_OP_WDC1    5'h14
`define MIE_OP_WDC2    5'h15
`define MIE_OP_SWAPM   5'h16
`define MIE_OP_NIBBLE_EXCHANGE_TO_ACC   5'h17
`define MIE_OP_HALT    5'h18
`define MIE_OP_ADC     5'h19
`define MIE_OP_ADD     5'h1a
`define MIE_OP_ADDI    5'h1b
`define MIE_OP_AND     5'h1c
`define MIE_OP_ANDI    5'h1d

`endif

// >>> mie_dmem.v
/*
 * Data memory of the core: 256 bytes, one write port, registered read.
 * Assumes one clock; read data follow the address by one edge.
 */
`timescale 1ns/1ps
module mie_dmem (
	// Clock
	input  wire       clk,
	// Access port
	input  wire [7:0] addr,
	input  wire       we,
	input  wire [7:0] wdata,
	output reg  [7:0] rdata
);
	reg [7:0] mem [0:255];

	always @(posedge clk) begin
		if (we)
			mem[addr] <= wdata;
		rdata <= mem[addr];
	end
endmodule

// >>> mie_core.v
/*
 * Execution core for a subset of an 8-bit instruction set, with an APB
 * register window, internal data memory and a program memory fetch port.
 * Assumes a program memory that presents prog_data combinationally, before the
 * edge that follows a prog_addr change, and an APB master on pclk.
 */
// Functional notes
// [RL1] Zero and bit tests skip next when true
// [RL2] Taken skip adds one instruction cycle
// [RL3] Writing program counter low adds a cycle
// [RL4] Inc/dec skip on zero; acc forms
// [RL5] Zero skip copies byte to accumulator
// [RL6] Call pushes next address, jumps, two cycles
// [RL7] Returns pop stack; immediate loads accumulator
// [RL8] Current page table read to memory, high
// [RL9] Last page table read, two cycles
// [RL10] Clear byte to zero, flags untouched
// [RL11] Clear selected bit, flags untouched
// [RL12] Watchdog clear zeros count and both flags
// [RL13] Preclear pair clears only when completed
// [RL14] Add with carry updates four flags
// [RL15] Plain add updates four flags
// [RL16] AND affects only zero flag
// [RL17] Nibble swap, accumulator form keeps memory
// [RL18] Jump loads program counter, no flags
// [RL19] Halt stops, clears watchdog, sets power-down
// [RL20] Single preclear only records itself
// [RL21] Interrupt return sets global enable
// [RL22] Set byte to all ones
// [RL23] No-operation advances one, one cycle
`timescale 1ns/1ps
`include "mie_defs.vh"
module mie_core (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg         pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	// Program memory
	output reg  [10:0] prog_addr,
	input  wire [15:0] prog_data
);
	localparam S_IDLE  = 6'b000001;
	localparam S_FETCH = 6'b000010;
	localparam S_WAIT  = 6'b000100;
	localparam S_DEC   = 6'b001000;
	localparam S_EXEC  = 6'b010000;
	localparam S_HOLD  = 6'b100000;

	reg  [5:0]  st_reg;
	reg  [10:0] pc_reg;
	reg  [15:0] ir_reg;
	reg  [7:0]  acc_reg;
	reg  [7:0]  table_high_byte_reg;
	reg  [2:0]  sp_reg;
	reg  [10:0] stk [0:7];
	reg         c_reg;
	reg         ac_reg;
	reg         z_reg;
	reg         ov_reg;
	reg         pdf_reg;
	reg         to_reg;
	reg         gie_reg;
	reg         run_reg;
	reg         halted_reg;
	reg  [3:0]  hold_reg;
	reg  [7:0]  wdt_reg;
	reg  [3:0]  pre_reg;
	reg  [1:0]  div_reg;
	reg         wdr_reg;
	reg         pc1_reg;
	reg         pc2_reg;
	reg  [7:0]  maddr_reg;
	reg  [1:0]  last_n_reg;
	reg         last_sk_reg;

	wire [7:0]  mem_rdata;
	wire        busy = ~st_reg[0];
	wire        exec = (st_reg == S_EXEC);
	wire [4:0]  opc = ir_reg[15:11];
	wire [2:0]  bsel = ir_reg[10:8];
	wire [7:0]  opd = ir_reg[7:0];
	wire [10:0] pc_inc = pc_reg + 11'h001;
	wire [10:0] stk_top = stk[sp_reg - 3'h1];
	wire [7:0]  m_val = (opd == `MIE_PCL_ADDR) ? pc_reg[7:0] : mem_rdata;
	wire        apb_done = psel & penable & pready;
	wire        wd_tick = run_reg & (div_reg == 2'h3);
	wire        go_on = run_reg & ~halted_reg & ~wdr_reg;

	// Adder shared by the three add forms
	wire [7:0]  add_b = (opc == `MIE_OP_ADDI) ? opd : m_val;
	wire        add_ci = (opc == `MIE_OP_ADC) ? c_reg : 1'b0;
	wire [8:0]  sum = {1'b0, acc_reg} + {1'b0, add_b} + {8'h00, add_ci};
	wire [4:0]  nib = {1'b0, acc_reg[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};
	wire [7:0]  m_inc = m_val + 8'h01;
	wire [7:0]  m_dec = m_val - 8'h01;

	reg  [7:0]  x_res;
	reg         x_wm;
	reg         x_wa;
	reg         x_skip;
	reg  [1:0]  x_base;
	reg         x_jmp;
	reg         x_push;
	reg         x_pop;
	reg         x_fz;
	reg         x_far;
	reg         x_gie;
	reg         x_tbl;
	reg         x_halt;
	reg         x_wdc;
	reg         x_wdc1;
	reg         x_wdc2;

	// Instruction decode
	always @* begin
		x_res = m_val;
		x_wm = 1'b0;
		x_wa = 1'b0;
		x_skip = 1'b0;
		x_base = 2'h1;
		x_jmp = 1'b0;
		x_push = 1'b0;
		x_pop = 1'b0;
		x_fz = 1'b0;
		x_far = 1'b0;
		x_gie = 1'b0;
		x_tbl = 1'b0;
		x_halt = 1'b0;
		x_wdc = 1'b0;
		x_wdc1 = 1'b0;
		x_wdc2 = 1'b0;
		case (opc)
			`MIE_OP_JMP: begin
				x_base = 2'h2;
				x_jmp = 1'b1;                          // [RL18]
			end
			`MIE_OP_CALL: begin
				x_base = 2'h2;
				x_jmp = 1'b1;
				x_push = 1'b1;                         // [RL6]
			end
			`MIE_OP_RET: begin
				x_base = 2'h2;
				x_pop = 1'b1;                          // [RL7]
			end
			`MIE_OP_RETA: begin
				x_base = 2'h2;
				x_pop = 1'b1;
				x_res = opd;
				x_wa = 1'b1;                           // [RL7]
			end
			`MIE_OP_INTERRUPT_RETURN: begin
				x_base = 2'h2;
				x_pop = 1'b1;
				x_gie = 1'b1;                          // [RL21]
			end
			`MIE_OP_SKZ:
				x_skip = (m_val == 8'h00);             // [RL1]
			`MIE_OP_SKZA: begin
				x_wa = 1'b1;
				x_skip = (m_val == 8'h00);             // [RL5]
			end
			`MIE_OP_SKBC:
				x_skip = ~m_val[bsel];                 // [RL1]
			`MIE_OP_SKBS:
				x_skip = m_val[bsel];                  // [RL1]
			`MIE_OP_INCSK, `MIE_OP_INCSKA: begin
				x_res = m_inc;
				x_wm = (opc == `MIE_OP_INCSK);
				x_wa = ~x_wm;
				x_skip = (m_inc == 8'h00);             // [RL4]
			end
			`MIE_OP_DECSK, `MIE_OP_DECSKA: begin
				x_res = m_dec;
				x_wm = (opc == `MIE_OP_DECSK);
				x_wa = ~x_wm;
				x_skip = (m_dec == 8'h00);             // [RL4]
			end
			`MIE_OP_TRDC, `MIE_OP_TRDL: begin
				x_base = 2'h2;
				x_res = prog_data[7:0];
				x_wm = 1'b1;
				x_tbl = 1'b1;                          // [RL8] [RL9]
			end
			`MIE_OP_CLRM: begin
				x_res = 8'h00;
				x_wm = 1'b1;                           // [RL10]
			end
			`MIE_OP_SETM: begin
				x_res = 8'hff;
				x_wm = 1'b1;                           // [RL22]
			end
			`MIE_OP_CLRB: begin
				x_res = m_val & ~(8'h01 << bsel);
				x_wm = 1'b1;                           // [RL11]
			end
			`MIE_OP_WDC:
				x_wdc = 1'b1;
			`MIE_OP_WDC1:
				x_wdc1 = 1'b1;
			`MIE_OP_WDC2:
				x_wdc2 = 1'b1;
			`MIE_OP_SWAPM, `MIE_OP_NIBBLE_EXCHANGE_TO_ACC: begin
				x_res = {m_val[3:0], m_val[7:4]};
				x_wm = (opc == `MIE_OP_SWAPM);
				x_wa = ~x_wm;                          // [RL17]
			end
			`MIE_OP_HALT:
				x_halt = 1'b1;
			`MIE_OP_ADC, `MIE_OP_ADD, `MIE_OP_ADDI: begin
				x_res = sum[7:0];
				x_far = 1'b1;
				x_wm = ir_reg[10] & (opc != `MIE_OP_ADDI);
				x_wa = ~x_wm;                          // [RL14] [RL15]
			end
			`MIE_OP_AND, `MIE_OP_ANDI: begin
				x_res = acc_reg & ((opc == `MIE_OP_ANDI) ? opd : m_val);
				x_fz = 1'b1;
				x_wm = ir_reg[10] & (opc == `MIE_OP_AND);
				x_wa = ~x_wm;                          // [RL16]
			end
			default: begin
				x_res = m_val;                         // [RL23]
			end
		endcase
	end

	// Cycle count and next program counter
	wire        pcl_w = x_wm & (opd == `MIE_PCL_ADDR);
	wire [1:0]  x_n = x_base + {1'b0, x_skip} + {1'b0, pcl_w};   // [RL2] [RL3]
	reg  [10:0] x_pcn;

	always @* begin
		if (pcl_w)
			x_pcn = {pc_reg[10:8], x_res};             // [RL3]
		else if (x_jmp)
			x_pcn = ir_reg[10:0];                      // [RL6] [RL18]
		else if (x_pop)
			x_pcn = stk_top;                           // [RL7]
		else if (x_skip)
			x_pcn = pc_reg + 11'h002;                  // [RL1]
		else
			x_pcn = pc_inc;                            // [RL23]
	end

	// Data memory shared with the register window while idle
	wire [7:0]  mem_addr = busy ? opd : maddr_reg;
	wire        mem_we = busy ? (exec & x_wm & ~pcl_w) :
		(apb_done & ~pslverr & pwrite & (paddr == `MIE_OFF_MDATA));
	wire [7:0]  mem_wd = busy ? x_res : pwdata[7:0];

	mie_dmem u_dmem (
		.clk   (pclk),
		.addr  (mem_addr),
		.we    (mem_we),
		.wdata (mem_wd),
		.rdata (mem_rdata)
	);

	// Hardware stack, wraps after eight levels
	always @(posedge pclk) begin
		if (exec && x_push)
			stk[sp_reg] <= pc_inc;                     // [RL6]
	end

	// Core sequencer, flags, watchdog and register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= S_IDLE;
			pc_reg <= `MIE_RST_PC;
			ir_reg <= 16'h0000;
			acc_reg <= `MIE_RST_ACC;
			table_high_byte_reg <= 8'h00;
			sp_reg <= `MIE_RST_SP;
			{c_reg, ac_reg, z_reg, ov_reg} <= 4'h0;
			{pdf_reg, to_reg, gie_reg} <= 3'h0;
			run_reg <= 1'b0;
			halted_reg <= 1'b0;
			hold_reg <= 4'h0;
			wdt_reg <= 8'h00;
			pre_reg <= 4'h0;
			div_reg <= 2'h0;
			wdr_reg <= 1'b0;
			{pc1_reg, pc2_reg} <= 2'h0;
			maddr_reg <= 8'h00;
			last_n_reg <= 2'h0;
			last_sk_reg <= 1'b0;
			prog_addr <= `MIE_RST_PC;
		end else begin
			if (apb_done && pwrite && !pslverr) begin
				if (paddr == `MIE_OFF_CTRL) begin
					run_reg <= pwdata[`MIE_CTRL_RUN];
					gie_reg <= pwdata[`MIE_CTRL_GIE];
					if (pwdata[`MIE_CTRL_WAKE])
						halted_reg <= 1'b0;
				end else if (paddr == `MIE_OFF_PC) begin
					pc_reg <= pwdata[10:0];
				end else if (paddr == `MIE_OFF_ACC) begin
					acc_reg <= pwdata[7:0];
				end else if (paddr == `MIE_OFF_MADDR) begin
					maddr_reg <= pwdata[7:0];
				end
			end
			// Watchdog counts instruction cycles while run is set
			if (run_reg)
				div_reg <= div_reg + 2'h1;
			if (wd_tick) begin
				pre_reg <= pre_reg + 4'h1;
				if (pre_reg == 4'hf)
					wdt_reg <= wdt_reg + 8'h01;
			end
			case (st_reg)
				S_IDLE: begin
					if (wdr_reg) begin
						pc_reg <= `MIE_RST_PC;
						sp_reg <= `MIE_RST_SP;
						halted_reg <= 1'b0;
						wdr_reg <= 1'b0;
					end else if (run_reg && !halted_reg) begin
						st_reg <= S_FETCH;
					end
				end
				S_FETCH: begin
					prog_addr <= pc_reg;
					st_reg <= S_WAIT;
				end
				S_WAIT: begin
					ir_reg <= prog_data;
					st_reg <= S_DEC;
				end
				S_DEC: begin
					if (opc == `MIE_OP_TRDC)
						prog_addr <= {pc_reg[10:8], acc_reg};          // [RL8]
					else if (opc == `MIE_OP_TRDL)
						prog_addr <= {`MIE_LAST_PAGE, acc_reg};        // [RL9]
					st_reg <= S_EXEC;
				end
				S_EXEC: begin
					if (x_wa)
						acc_reg <= x_res;
					if (x_fz)
						z_reg <= (x_res == 8'h00);                     // [RL16]
					if (x_far) begin
						c_reg <= sum[8];
						ac_reg <= nib[4];
						ov_reg <= (acc_reg[7] == add_b[7]) & (sum[7] != acc_reg[7]);
						z_reg <= (sum[7:0] == 8'h00);                  // [RL14] [RL15]
					end
					if (x_tbl)
						table_high_byte_reg <= prog_data[15:8];                   // [RL8]
					if (x_push)
						sp_reg <= sp_reg + 3'h1;
					if (x_pop)
						sp_reg <= sp_reg - 3'h1;
					if (x_gie)
						gie_reg <= 1'b1;                               // [RL21]
					if (x_wdc) begin
						wdt_reg <= 8'h00;
						pre_reg <= 4'h0;
						{pdf_reg, to_reg} <= 2'h0;                     // [RL12]
					end
					if (x_wdc1 || x_wdc2) begin
						if ((x_wdc1 && pc2_reg) || (x_wdc2 && pc1_reg)) begin
							wdt_reg <= 8'h00;
							pre_reg <= 4'h0;
							{pdf_reg, to_reg} <= 2'h0;                 // [RL13]
							{pc1_reg, pc2_reg} <= 2'h0;
						end else if (x_wdc1) begin
							pc1_reg <= 1'b1;                           // [RL20]
						end else begin
							pc2_reg <= 1'b1;                           // [RL20]
						end
					end
					if (x_halt) begin
						halted_reg <= 1'b1;
						wdt_reg <= 8'h00;
						pre_reg <= 4'h0;
						pdf_reg <= 1'b1;
						to_reg <= 1'b0;                                // [RL19]
					end
					pc_reg <= x_pcn;
					last_n_reg <= x_n;
					last_sk_reg <= x_skip;
					if (x_n == 2'h1) begin
						st_reg <= (go_on && !x_halt) ? S_FETCH : S_IDLE;
					end else begin
						hold_reg <= ({2'b00, x_n} - 4'h1) * `MIE_SYS_PER_ICYC - 4'h1;
						st_reg <= S_HOLD;                              // [RL2] [RL3]
					end
				end
				S_HOLD: begin
					if (hold_reg == 4'h0)
						st_reg <= go_on ? S_FETCH : S_IDLE;
					else
						hold_reg <= hold_reg - 4'h1;
				end
				default: st_reg <= S_IDLE;
			endcase
			// Time-out wins over any clear in the same cycle
			if (wd_tick && wdt_reg == 8'hff && pre_reg == 4'hf) begin
				to_reg <= 1'b1;
				wdr_reg <= 1'b1;
			end
		end
	end

	// Register window read data and error decode
	wire unmapped = (paddr[1:0] != 2'h0) || (paddr > `MIE_OFF_LAST);
	wire locked = busy & ((pwrite & ((paddr == `MIE_OFF_PC) | (paddr == `MIE_OFF_ACC))) |
		(paddr == `MIE_OFF_MDATA));
	reg  [31:0] rd_mux;

	always @* begin
		rd_mux = 32'h0000_0000;
		if (paddr == `MIE_OFF_CTRL) begin
			rd_mux[`MIE_CTRL_RUN] = run_reg;
			rd_mux[`MIE_CTRL_GIE] = gie_reg;
		end else if (paddr == `MIE_OFF_STAT) begin
			rd_mux[`MIE_ST_C] = c_reg;
			rd_mux[`MIE_ST_AC] = ac_reg;
			rd_mux[`MIE_ST_Z] = z_reg;
			rd_mux[`MIE_ST_OV] = ov_reg;
			rd_mux[`MIE_ST_PDF] = pdf_reg;
			rd_mux[`MIE_ST_TO] = to_reg;
			rd_mux[`MIE_ST_HALT] = halted_reg;
			rd_mux[`MIE_ST_BUSY] = busy;
		end else if (paddr == `MIE_OFF_PC) begin
			rd_mux[10:0] = pc_reg;
		end else if (paddr == `MIE_OFF_ACC) begin
			rd_mux[7:0] = acc_reg;
		end else if (paddr == `MIE_OFF_TABLE_HIGH_BYTE) begin
			rd_mux[7:0] = table_high_byte_reg;
		end else if (paddr == `MIE_OFF_WDT) begin
			rd_mux[7:0] = wdt_reg;
		end else if (paddr == `MIE_OFF_MADDR) begin
			rd_mux[7:0] = maddr_reg;
		end else if (paddr == `MIE_OFF_MDATA) begin
			rd_mux[7:0] = mem_rdata;
		end else if (paddr == `MIE_OFF_LAST) begin
			rd_mux[1:0] = last_n_reg;
			rd_mux[2] = last_sk_reg;
		end
	end

	// One wait state on every transfer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel && penable && !pready) begin
				prdata <= (unmapped | locked) ? 32'h0000_0000 : rd_mux;
				pslverr <= unmapped | locked;
			end
		end
	end
endmodule

// >>> mie_monitor.sv
/* Checker on the core's APB and fetch ports.
 * Assumes binding to mie_core, one clock, active-low reset. */
`timescale 1ns/1ps
module mie_monitor (
	// Clock and reset
	input wire        pclk,
	input wire        presetn,
	// APB
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire [31:0] prdata,
	input wire        pslverr,
	// Program memory
	input wire [10:0] prog_addr,
	input wire [15:0] prog_data
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_one_wait;
		$rose(penable) && psel |-> !pready ##1 pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("ready not after one wait state");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	property p_idle;
		!(psel && penable) |-> !pready;
	endproperty
	a_idle: assert property (p_idle) else $error("ready outside access phase");
	property p_unmapped;
		pready && (paddr[1:0] != 2'h0 || paddr > 8'h20) |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_ro_write;
		pready && pwrite && (paddr == 8'h04 || paddr == 8'h10 || paddr == 8'h20) |-> !pslverr;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write flagged");
	property p_read_ok;
		pready && !pwrite && paddr[1:0] == 2'h0 && paddr <= 8'h20 && paddr != 8'h1c |-> !pslverr;
	endproperty
	a_read_ok: assert property (p_read_ok) else $error("mapped read flagged");
	property p_hold;
		!pready |-> $stable(prdata) && $stable(pslverr);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without ready");
	property p_stat_upper;
		pready && !pwrite && paddr == 8'h04 |-> prdata[31:8] == 24'h0;
	endproperty
	a_stat_upper: assert property (p_stat_upper) else $error("status upper bits set");
	property p_fetch_gap;
		$changed(prog_addr) |=> $stable(prog_addr);
	endproperty
	a_fetch_gap: assert property (p_fetch_gap) else $error("fetch addresses too close");
	property p_reset_vals;
		$rose(presetn) |-> !pready && prog_addr == 11'h0 && prdata == 32'h0;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("outputs not at reset values");

	c_write: cover property (pready && pwrite);
	c_read: cover property (pready && !pwrite);
	c_err: cover property (pready && pslverr);
endmodule

bind mie_core mie_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data));

// >>> mie_prog_model.sv
/* Program memory model: 2048 words, zero-latency read.
 * Assumes the bench preloads words into mem before each run. */
`timescale 1ns/1ps
module mie_prog_model (
	// Fetch port
	input  wire [10:0] prog_addr,
	output wire [15:0] prog_data
);
	reg [15:0] mem [0:2047];
	integer    i;

	initial begin
		for (i = 0; i < 2048; i = i + 1)
			mem[i] = 16'h0000;
	end
	assign prog_data = mem[prog_addr];
endmodule

// >>> test_mcu_instruction_execute_subset.sv
/* Bench for the execution core: APB tasks, program loads, fetch timing.
 * Assumes the core, its header and the program memory model. */
`timescale 1ns/1ps
`include "mie_defs.vh"
module test_mcu_instruction_execute_subset;
	reg         pclk, presetn, psel, penable, pwrite, serr;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata, rd;
	reg  [10:0] last_pa;
	wire        pready, pslverr;
	wire [31:0] prdata;
	wire [10:0] prog_addr;
	wire [15:0] prog_data;
	integer     err_count, compares, cyc;
	integer     stamp [0:2047];

	mie_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.prog_addr(prog_addr), .prog_data(prog_data));
	mie_prog_model u_prog (.prog_addr(prog_addr), .prog_data(prog_data));

	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end

	task report_and_stop;
		$display("compares=%0d errors=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Stamp the cycle each fetch address appears; hang guard
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (prog_addr !== last_pa)
			stamp[prog_addr] = cyc;
		last_pa = prog_addr;
		if (cyc > 20000) begin
			err_count = err_count + 1;
			report_and_stop;
		end
	end

	task chk(input string nm, input [31:0] exp, input [31:0] got);
		compares = compares + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("CHECK FAILED %s exp=%h got=%h", nm, exp, got);
		end
	endtask

	task apb(input w, input [7:0] a, input [31:0] d);
		integer n;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n = n + 1;
		end while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1)
			err_count = err_count + 1;
		rd = prdata;
		serr = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	task wr(input [7:0] a, input [31:0] d);
		apb(1'h1, a, d);
	endtask

	task rdc(input string nm, input [7:0] a, input [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(nm, exp, rd);
	endtask

	task mchk(input [7:0] a, input [31:0] exp);
		wr(`MIE_OFF_MADDR, {24'h0, a});
		rdc("mem", `MIE_OFF_MDATA, exp);
	endtask

	task mset(input [7:0] a, input [7:0] d);
		wr(`MIE_OFF_MADDR, {24'h0, a});
		wr(`MIE_OFF_MDATA, {24'h0, d});
	endtask

	task ld(input [10:0] a, input [4:0] op, input [2:0] b, input [7:0] m);
		u_prog.mem[a] = {op, b, m};
	endtask

	task gap(input [10:0] a, input [10:0] b, input [31:0] exp);
		chk("fetch gap", exp, stamp[b] - stamp[a]);
	endtask

	// Run from pc until endpc is fetched, stop, wait for idle; rd holds status
	task go(input [10:0] pc, input [10:0] endpc);
		integer n;
		wr(`MIE_OFF_PC, {21'h0, pc});
		wr(`MIE_OFF_CTRL, 32'h5);
		n = 0;
		while (prog_addr !== endpc && n < 400) begin
			@(posedge pclk);
			n = n + 1;
		end
		if (n >= 400)
			err_count = err_count + 1;
		// Stop without losing an enable set by the program
		apb(1'h0, `MIE_OFF_CTRL, 32'h0);
		wr(`MIE_OFF_CTRL, rd & 32'h2);
		n = 0;
		do begin
			apb(1'h0, `MIE_OFF_STAT, 32'h0);
			n = n + 1;
		end while (rd[7] !== 1'h0 && n < 20);
		if (rd[7] !== 1'h0)
			err_count = err_count + 1;
	endtask

	initial begin
		cyc = 0;
		err_count = 0;
		compares = 0;
		last_pa = 11'h0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		rdc("stat", `MIE_OFF_STAT, 32'h0);
		rdc("acc", `MIE_OFF_ACC, 32'h0);
		apb(1'h0, 8'h24, 32'h0);
		chk("slverr", 32'h1, {31'h0, serr});
		wr(`MIE_OFF_STAT, 32'hff);
		chk("slverr", 32'h0, {31'h0, serr});
		ld(11'h010, `MIE_OP_NOP, 3'h0, 8'h00);
		ld(11'h011, `MIE_OP_JMP, 3'h0, 8'h18);
		ld(11'h018, `MIE_OP_HALT, 3'h0, 8'h00);
		go(11'h010, 11'h018);
		chk("stat", 32'h50, rd);
		gap(11'h010, 11'h011, 4);
		gap(11'h011, 11'h018, 8);
		mset(8'h70, 8'h00);
		mset(8'h71, 8'h08);
		mset(8'h72, 8'h01);
		mset(8'h73, 8'hff);
		mset(8'h74, 8'h33);
		ld(11'h020, `MIE_OP_SKZ, 3'h0, 8'h70);
		ld(11'h021, `MIE_OP_SETM, 3'h0, 8'h74);
		ld(11'h022, `MIE_OP_SKBS, 3'h3, 8'h71);
		ld(11'h023, `MIE_OP_CLRM, 3'h0, 8'h71);
		ld(11'h024, `MIE_OP_DECSK, 3'h0, 8'h72);
		ld(11'h025, `MIE_OP_SETM, 3'h0, 8'h74);
		ld(11'h026, `MIE_OP_INCSKA, 3'h0, 8'h73);
		ld(11'h027, `MIE_OP_SETM, 3'h0, 8'h74);
		ld(11'h028, `MIE_OP_SKZA, 3'h0, 8'h71);
		ld(11'h029, `MIE_OP_SKBC, 3'h0, 8'h71);
		ld(11'h02a, `MIE_OP_SETM, 3'h0, 8'h74);
		ld(11'h02b, `MIE_OP_JMP, 3'h0, 8'h2b);
		go(11'h020, 11'h02b);
		gap(11'h020, 11'h022, 8);
		gap(11'h022, 11'h024, 8);
		gap(11'h024, 11'h026, 8);
		gap(11'h026, 11'h028, 8);
		gap(11'h028, 11'h029, 4);
		gap(11'h029, 11'h02b, 8);
		mchk(8'h74, 32'h33);
		mchk(8'h71, 32'h08);
		mchk(8'h72, 32'h00);
		mchk(8'h73, 32'hff);
		rdc("acc", `MIE_OFF_ACC, 32'h08);
		ld(11'h030, `MIE_OP_CALL, 3'h0, 8'h40);
		ld(11'h031, `MIE_OP_CALL, 3'h0, 8'h41);
		ld(11'h032, `MIE_OP_JMP, 3'h0, 8'h32);
		ld(11'h040, `MIE_OP_RETA, 3'h0, 8'h5a);
		ld(11'h041, `MIE_OP_INTERRUPT_RETURN, 3'h0, 8'h00);
		go(11'h030, 11'h032);
		gap(11'h030, 11'h040, 8);
		gap(11'h040, 11'h031, 8);
		gap(11'h041, 11'h032, 8);
		rdc("acc", `MIE_OFF_ACC, 32'h5a);
		apb(1'h0, `MIE_OFF_CTRL, 32'h0);
		chk("gie", 32'h2, rd & 32'h2);
		wr(`MIE_OFF_ACC, 32'h40);
		u_prog.mem[11'h140] = 16'hbeef;
		u_prog.mem[11'h740] = 16'hc0de;
		ld(11'h100, `MIE_OP_TRDC, 3'h0, 8'h50);
		ld(11'h101, `MIE_OP_TRDL, 3'h0, 8'h51);
		ld(11'h102, `MIE_OP_JMP, 3'h1, 8'h02);
		go(11'h100, 11'h102);
		gap(11'h100, 11'h101, 8);
		gap(11'h101, 11'h102, 8);
		mchk(8'h50, 32'hef);
		mchk(8'h51, 32'hde);
		rdc("table_high_byte", `MIE_OFF_TABLE_HIGH_BYTE, 32'hc0);
		mset(8'h60, 8'ha5);
		mset(8'h62, 8'hff);
		mset(8'h63, 8'h12);
		mset(8'h64, 8'h34);
		mset(8'h65, 8'h7f);
		ld(11'h200, `MIE_OP_CLRM, 3'h0, 8'h60);
		ld(11'h201, `MIE_OP_SETM, 3'h0, 8'h61);
		ld(11'h202, `MIE_OP_CLRB, 3'h3, 8'h62);
		ld(11'h203, `MIE_OP_SWAPM, 3'h0, 8'h63);
		ld(11'h204, `MIE_OP_NIBBLE_EXCHANGE_TO_ACC, 3'h0, 8'h64);
		ld(11'h205, `MIE_OP_ADDI, 3'h0, 8'hbd);
		ld(11'h206, `MIE_OP_ANDI, 3'h0, 8'hff);
		ld(11'h207, `MIE_OP_ADC, 3'h4, 8'h65);
		ld(11'h208, `MIE_OP_ANDI, 3'h0, 8'h00);
		ld(11'h209, `MIE_OP_HALT, 3'h0, 8'h00);
		go(11'h200, 11'h209);
		chk("stat", 32'h5e, rd);
		gap(11'h204, 11'h205, 4);
		mchk(8'h60, 32'h00);
		mchk(8'h61, 32'hff);
		mchk(8'h62, 32'hf7);
		mchk(8'h63, 32'h21);
		mchk(8'h64, 32'h34);
		mchk(8'h65, 32'h80);
		rdc("acc", `MIE_OFF_ACC, 32'h00);
		ld(11'h400, `MIE_OP_SETM, 3'h0, 8'h02);
		ld(11'h4ff, `MIE_OP_JMP, 3'h4, 8'hff);
		go(11'h400, 11'h4ff);
		gap(11'h400, 11'h4ff, 8);
		ld(11'h300, `MIE_OP_WDC1, 3'h0, 8'h00);
		ld(11'h301, `MIE_OP_JMP, 3'h3, 8'h01);
		go(11'h300, 11'h301);
		chk("stat", 32'h1e, rd);
		ld(11'h310, `MIE_OP_WDC2, 3'h0, 8'h00);
		ld(11'h311, `MIE_OP_JMP, 3'h3, 8'h11);
		go(11'h310, 11'h311);
		chk("stat", 32'h0e, rd);
		ld(11'h320, `MIE_OP_HALT, 3'h0, 8'h00);
		go(11'h320, 11'h320);
		ld(11'h330, `MIE_OP_WDC, 3'h0, 8'h00);
		ld(11'h331, `MIE_OP_JMP, 3'h3, 8'h31);
		go(11'h330, 11'h331);
		chk("stat", 32'h0e, rd);
		rdc("wdt", `MIE_OFF_WDT, 32'h0);
		report_and_stop;
	end
endmodule
